// ### design/uart_rx_map.vh
// register offsets, field positions, reset values and sample tick positions of the receiver
`ifndef UART_RX_MAP_VH
`define UART_RX_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL 8'h00
`define OFS_IRQ_EN 8'h04
`define OFS_STATUS 8'h08
`define OFS_DATA 8'h0C
`define OFS_BAUD 8'h10

// ****************************************************************
// control register fields
// ****************************************************************
`define CTRL_ENABLE 0
`define CTRL_RX_ENABLE 1
`define CTRL_CHAR_LEN9 2
`define CTRL_WAKE_METHOD 3
`define CTRL_IDLE_ORIGIN 4
`define CTRL_PARITY_EN 5
`define CTRL_PARITY_ODD 6
`define CTRL_STANDBY 7
`define CTRL_RESET 8'h00

// ****************************************************************
// status and enable fields, same position in both registers, busy in status only
// ****************************************************************
`define ST_RX_FULL 0
`define ST_IDLE 1
`define ST_OVERRUN 2
`define ST_NOISE 3
`define ST_FRAMING 4
`define ST_PARITY 5
`define ST_BUSY 6
`define IRQ_EN_RESET 6'h00

// ****************************************************************
// baud divider and oversample tick positions
// ****************************************************************
`define BAUD_DIV_RESET 16'h0041
`define RT_PER_BIT 5'h10
`define RT_FIRST 5'h01
`define RT_VERIFY_A 5'h03
`define RT_VERIFY_B 5'h05
`define RT_VERIFY_C 5'h07
`define RT_SAMPLE_A 5'h08
`define RT_SAMPLE_B 5'h09
`define RT_SAMPLE_C 5'h0A
`define IDLE_TICKS_8 8'hA0
`define IDLE_TICKS_9 8'hB0

`endif

// ### design/uart_tick_gen.v
// divider that makes the one-cycle oversample tick enable
`timescale 1ns/10ps
module uart_tick_gen #(
  parameter DIV_W = 16
) (
  input wire sys_clk,
  input wire rst,
  input wire run,
  input wire restart,
  input wire [DIV_W-1:0] divisor,
  output reg tick
);
  reg [DIV_W-1:0] count_reg;

  // ****************************************************************
  // divider
  // ****************************************************************
  // divisor 0 or 1 gives a tick on every clock while running
  always @(posedge sys_clk) begin
    if (rst) begin
      count_reg <= {DIV_W{1'b0}};
      tick <= 1'b0;
    end else if (!run || restart) begin
      count_reg <= {DIV_W{1'b0}};
      tick <= 1'b0;
    end else if (count_reg + {{(DIV_W-1){1'b0}}, 1'b1} >= divisor) begin
      count_reg <= {DIV_W{1'b0}};
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // uart_tick_gen

// ### design/uart_receive_recovery.v
// receive side of the serial unit with wishbone register access
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "uart_rx_map.vh"
module uart_receive_recovery #(
  parameter DIV_W = 16
) (
  input wire sys_clk,
  input wire rst,
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [7:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatIn,
  output reg [31:0] wbDatOut,
  output wire wbAck,
  input wire rxd,
  input wire lightSleep,
  input wire deepSleep,
  output reg rxIrq,
  output reg errIrq,
  output reg wakeCpu
);
  localparam [3:0] S_SEARCH = 4'b0001;
  localparam [3:0] S_START = 4'b0010;
  localparam [3:0] S_DATA = 4'b0100;
  localparam [3:0] S_STOP = 4'b1000;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function maj3;
    input [2:0] v;
    begin
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    end
  endfunction

  function mixed3;
    input [2:0] v;
    begin
      mixed3 = (|v) & ~(&v);
    end
  endfunction

  // ****************************************************************
  // registers and state
  // ****************************************************************
  reg [7:0] ctrl_reg;
  reg [5:0] irqEn_reg;
  reg [5:0] flags_reg;
  reg [8:0] rxData_reg;
  reg [DIV_W-1:0] baud_reg;
  reg ack_reg;
  reg [3:0] state_reg;
  reg [4:0] rtCnt_reg;
  reg [3:0] bitIdx_reg;
  reg [8:0] shift_reg;
  reg [2:0] hist_reg;
  reg [2:1] verify_reg;
  reg [2:0] samp_reg;
  reg noiseAcc_reg;
  reg edgeArmed_reg;
  reg prevSample_reg;
  reg [7:0] idleTicks_reg;
  reg idleSeen_reg;
  reg idleEvent_reg;
  reg charDone_reg;
  reg [8:0] doneData_reg;
  reg doneFraming_reg;
  reg doneNoise_reg;
  reg doneParity_reg;
  wire tick;
  wire run;
  wire charLen9;
  wire [3:0] lastBit;
  wire [2:0] sampNow;
  wire busAccess;
  wire wrStrobe;
  wire rdStrobe;
  wire dataRead;
  wire fullNow;
  wire msbHigh;
  wire storeChar;
  wire addrWake;
  wire idleWake;
  wire [7:0] idleTarget;
  wire idleAllowed;
  wire [5:0] w1c;
  reg [5:0] flags_next;
  reg [7:0] ctrl_next;

  // deep sleep freezes the receiver and keeps its state, while the tick divider count returns to zero
  assign run = ctrl_reg[`CTRL_ENABLE] & ctrl_reg[`CTRL_RX_ENABLE] & ~deepSleep;
  assign charLen9 = ctrl_reg[`CTRL_CHAR_LEN9];
  assign lastBit = charLen9 ? 4'h8 : 4'h7;
  assign sampNow = {samp_reg[1:0], rxd};

  // ****************************************************************
  // oversample tick
  // ****************************************************************
  uart_tick_gen #(
    .DIV_W(DIV_W)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(run),
    .restart(1'b0),
    .divisor(baud_reg),
    .tick(tick)
  );

  // ****************************************************************
  // bit recovery
  // ****************************************************************
  assign idleTarget = charLen9 ? `IDLE_TICKS_9 : `IDLE_TICKS_8;
  // origin zero counts from after the start bit, origin one only once the stop is done
  assign idleAllowed = ctrl_reg[`CTRL_IDLE_ORIGIN] ? (state_reg == S_SEARCH) :
                       (state_reg != S_START);

  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= S_SEARCH;
      rtCnt_reg <= `RT_FIRST;
      bitIdx_reg <= 4'h0;
      shift_reg <= 9'h000;
      hist_reg <= 3'h0;
      verify_reg <= 2'h0;
      samp_reg <= 3'h0;
      noiseAcc_reg <= 1'b0;
      edgeArmed_reg <= 1'b0;
      prevSample_reg <= 1'b1;
      idleTicks_reg <= 8'h00;
      idleSeen_reg <= 1'b0;
      idleEvent_reg <= 1'b0;
      charDone_reg <= 1'b0;
      doneData_reg <= 9'h000;
      doneFraming_reg <= 1'b0;
      doneNoise_reg <= 1'b0;
      doneParity_reg <= 1'b0;
    end else begin
      charDone_reg <= 1'b0;
      idleEvent_reg <= 1'b0;
      if (!run) begin
        if (!ctrl_reg[`CTRL_ENABLE] || !ctrl_reg[`CTRL_RX_ENABLE]) begin
          state_reg <= S_SEARCH;
          hist_reg <= 3'h0;
          idleTicks_reg <= 8'h00;
        end
      end else if (tick) begin
        prevSample_reg <= rxd;
        // consecutive high samples, sixteen per bit, toward an idle character
        if (!rxd || !idleAllowed) begin
          idleTicks_reg <= 8'h00;
          idleSeen_reg <= 1'b0;
        end else if (!idleSeen_reg) begin
          if (idleTicks_reg == idleTarget - 8'h01) begin
            idleSeen_reg <= 1'b1;
            idleEvent_reg <= 1'b1;
          end else begin
            idleTicks_reg <= idleTicks_reg + 8'h01;
          end
        end
        // tick count runs one to sixteen inside each bit
        if (rtCnt_reg == `RT_PER_BIT) begin
          rtCnt_reg <= `RT_FIRST;
        end else begin
          rtCnt_reg <= rtCnt_reg + 5'h01;
        end
        case (state_reg)
          S_SEARCH: begin
            hist_reg <= {hist_reg[1:0], rxd};
            if (hist_reg == 3'b111 && !rxd) begin
              state_reg <= S_START;
              rtCnt_reg <= 5'h02;
              noiseAcc_reg <= 1'b0;
              edgeArmed_reg <= 1'b0;
              bitIdx_reg <= 4'h0;
            end
          end
          S_START: begin
            if (rtCnt_reg == `RT_VERIFY_A) begin
              verify_reg[2] <= rxd;
            end
            if (rtCnt_reg == `RT_VERIFY_B) begin
              verify_reg[1] <= rxd;
            end
            if (rtCnt_reg == `RT_VERIFY_C) begin
              if (maj3({verify_reg[2:1], rxd})) begin
                state_reg <= S_SEARCH;
                hist_reg <= 3'h0;
                rtCnt_reg <= `RT_FIRST;
              end else if (mixed3({verify_reg[2:1], rxd})) begin
                noiseAcc_reg <= 1'b1;
              end
            end
            if (rtCnt_reg >= `RT_SAMPLE_A && rtCnt_reg <= `RT_SAMPLE_C) begin
              samp_reg <= sampNow;
            end
            // any high mid sample: noise, still taken as a start bit
            if (rtCnt_reg == `RT_SAMPLE_C && (|sampNow)) begin
              noiseAcc_reg <= 1'b1;
            end
            if (rtCnt_reg == `RT_PER_BIT) begin
              state_reg <= S_DATA;
            end
          end
          S_DATA: begin
            if (rtCnt_reg >= `RT_SAMPLE_A && rtCnt_reg <= `RT_SAMPLE_C) begin
              samp_reg <= sampNow;
            end
            if (rtCnt_reg == `RT_SAMPLE_C) begin
              shift_reg <= {maj3(sampNow), shift_reg[8:1]};
              edgeArmed_reg <= maj3(sampNow);
              if (mixed3(sampNow)) begin
                noiseAcc_reg <= 1'b1;
              end
            end
            // falling edge early in a bit after a one: restart the count here
            if (edgeArmed_reg && prevSample_reg && !rxd && rtCnt_reg > `RT_FIRST &&
                rtCnt_reg <= `RT_VERIFY_C) begin
              rtCnt_reg <= 5'h02;
              edgeArmed_reg <= 1'b0;
            end
            if (rtCnt_reg == `RT_PER_BIT) begin
              if (bitIdx_reg == lastBit) begin
                state_reg <= S_STOP;
              end else begin
                bitIdx_reg <= bitIdx_reg + 4'h1;
              end
            end
          end
          S_STOP: begin
            if (rtCnt_reg >= `RT_SAMPLE_A && rtCnt_reg <= `RT_SAMPLE_C) begin
              samp_reg <= sampNow;
            end
            if (rtCnt_reg == `RT_SAMPLE_C) begin
              charDone_reg <= 1'b1;
              doneData_reg <= charLen9 ? shift_reg : {1'b0, shift_reg[8:1]};
              // fewer than two highs is a framing error, break included
              doneFraming_reg <= ~maj3(sampNow);
              doneNoise_reg <= noiseAcc_reg | mixed3(sampNow);
              doneParity_reg <= ctrl_reg[`CTRL_PARITY_EN] &
                                ((charLen9 ? ^shift_reg : ^shift_reg[8:1]) !=
                                 ctrl_reg[`CTRL_PARITY_ODD]);
              state_reg <= S_SEARCH;
              hist_reg <= maj3(sampNow) ? 3'b111 : 3'b000;
              rtCnt_reg <= `RT_FIRST;
            end
          end
          default: begin
            state_reg <= S_SEARCH;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  assign busAccess = wbCyc & wbStb & ~ack_reg;
  assign wrStrobe = busAccess & wbWe;
  assign rdStrobe = busAccess & ~wbWe;
  assign wbAck = ack_reg;
  assign dataRead = rdStrobe && wbAdr == `OFS_DATA;
  assign w1c = (wrStrobe && wbAdr == `OFS_STATUS && wbSel[0]) ? wbDatIn[5:0] : 6'h00;

  // ****************************************************************
  // character hand-off and flags
  // ****************************************************************
  assign msbHigh = charLen9 ? doneData_reg[8] : doneData_reg[7];
  assign addrWake = charDone_reg & ctrl_reg[`CTRL_STANDBY] & ctrl_reg[`CTRL_WAKE_METHOD] &
                    msbHigh;
  assign idleWake = idleEvent_reg & ctrl_reg[`CTRL_STANDBY] &
                    ~ctrl_reg[`CTRL_WAKE_METHOD];
  // in standby only an address mark reaches the buffer
  assign storeChar = charDone_reg & (~ctrl_reg[`CTRL_STANDBY] | addrWake);
  // a read of the buffer in the same cycle frees it for the new character
  assign fullNow = flags_reg[`ST_RX_FULL] & ~dataRead;

  always @* begin
    flags_next = flags_reg & ~w1c;
    if (dataRead) begin
      flags_next[`ST_RX_FULL] = 1'b0;
    end
    if (storeChar) begin
      if (fullNow) begin
        flags_next[`ST_OVERRUN] = 1'b1;
      end else begin
        flags_next[`ST_RX_FULL] = 1'b1;
        flags_next[`ST_FRAMING] = flags_next[`ST_FRAMING] | doneFraming_reg;
        flags_next[`ST_NOISE] = flags_next[`ST_NOISE] | doneNoise_reg;
        flags_next[`ST_PARITY] = flags_next[`ST_PARITY] | doneParity_reg;
      end
    end
    if (idleEvent_reg && !ctrl_reg[`CTRL_STANDBY]) begin
      flags_next[`ST_IDLE] = 1'b1;
    end
  end

  always @* begin
    ctrl_next = ctrl_reg;
    if (addrWake || idleWake) begin
      ctrl_next[`CTRL_STANDBY] = 1'b0;
    end
    if (wrStrobe && wbAdr == `OFS_CTRL && wbSel[0]) begin
      ctrl_next = wbDatIn[7:0];
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= `CTRL_RESET;
      irqEn_reg <= `IRQ_EN_RESET;
      flags_reg <= 6'h00;
      rxData_reg <= 9'h000;
      baud_reg <= `BAUD_DIV_RESET;
      ack_reg <= 1'b0;
      wbDatOut <= 32'h00000000;
    end else begin
      ack_reg <= busAccess;
      ctrl_reg <= ctrl_next;
      flags_reg <= flags_next;
      if (storeChar && !fullNow) begin
        rxData_reg <= doneData_reg;
      end
      if (wrStrobe && wbAdr == `OFS_IRQ_EN && wbSel[0]) begin
        irqEn_reg <= wbDatIn[5:0];
      end
      if (wrStrobe && wbAdr == `OFS_BAUD) begin
        if (wbSel[0]) begin
          baud_reg[7:0] <= wbDatIn[7:0];
        end
        if (wbSel[1]) begin
          baud_reg[15:8] <= wbDatIn[15:8];
        end
      end
      if (rdStrobe) begin
        case (wbAdr)
          `OFS_CTRL: wbDatOut <= {24'h000000, ctrl_reg};
          `OFS_IRQ_EN: wbDatOut <= {26'h0, irqEn_reg};
          `OFS_STATUS: wbDatOut <= {25'h0, state_reg != S_SEARCH, flags_reg};
          `OFS_DATA: wbDatOut <= {23'h0, rxData_reg};
          `OFS_BAUD: wbDatOut <= {16'h0000, baud_reg};
          default: wbDatOut <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************************
  // interrupt requests
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (rst) begin
      rxIrq <= 1'b0;
      errIrq <= 1'b0;
      wakeCpu <= 1'b0;
    end else begin
      rxIrq <= ~ctrl_reg[`CTRL_STANDBY] &
               ((flags_reg[`ST_RX_FULL] & irqEn_reg[`ST_RX_FULL]) |
                (flags_reg[`ST_IDLE] & irqEn_reg[`ST_IDLE]));
      errIrq <= ~ctrl_reg[`CTRL_STANDBY] &
                |(flags_reg[5:2] & irqEn_reg[5:2]);
      wakeCpu <= lightSleep & (rxIrq | errIrq);
    end
  end
endmodule // uart_receive_recovery

// ### verification/uart_tx_model.sv
// serial transmitter model that drives the receive line
`timescale 1ns/10ps
module uart_tx_model (
  input wire sys_clk,
  output reg rxd
);
  initial rxd = 1'b1;
  // ****************************************
  // one line level per clock at a divisor of one
  // ****************************************
  task put(input logic v, input int n);
    repeat (n) begin
      rxd <= v;
      @(posedge sys_clk);
    end
  endtask
  // per is the bit period in clocks; sp gives stop samples 8, 9, 10; sn lifts start sample 9
  task send(input logic [7:0] d, input logic [2:0] sp, input logic sn, input int per);
    int i;
    put(1'b0, 8);
    put(sn, 1);
    put(1'b0, per - 9);
    for (i = 0; i < 8; i++) begin
      put(d[i], per);
    end
    put(sp[2], 8);
    put(sp[1], 1);
    // only the tenth sample carries sp[0]; the rest of the stop bit stays high
    put(sp[0], 1);
    put(1'b1, 10);
  endtask
endmodule // uart_tx_model

// ### verification/uart_receive_recovery_props.sv
// concurrent checks on the ports of the receive recovery block
`timescale 1ns/10ps
`include "uart_rx_map.vh"
module uart_rx_props #(
  parameter DIV_W = 16
) (
  input wire sys_clk,
  input wire rst,
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [7:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatIn,
  input wire [31:0] wbDatOut,
  input wire wbAck,
  input wire rxd,
  input wire lightSleep,
  input wire deepSleep,
  input wire rxIrq,
  input wire errIrq,
  input wire wakeCpu
);
  reg [5:0] enShadow_reg;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ****************************************
  // interrupt enables as last written, updated at the edge that takes the write
  // ****************************************
  always @(posedge sys_clk) begin
    if (rst) begin
      enShadow_reg <= 6'h00;
    end else if (wbCyc && wbStb && !wbAck && wbWe && wbAdr == `OFS_IRQ_EN && wbSel[0]) begin
      enShadow_reg <= wbDatIn[5:0];
    end
  end
  a_ack_prompt: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("request not acknowledged next cycle");
  a_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wbAck |-> $past(wbCyc && wbStb))
    else $error("ack without request");
  a_rdata_hold: assert property ($changed(wbDatOut) |-> wbAck && !wbWe)
    else $error("read data changed outside a read");
  a_unmapped_zero: assert property (wbAck && !wbWe && wbAdr > 8'h10 |-> wbDatOut == 32'h0)
    else $error("unmapped read not zero");
  a_status_width: assert property (wbAck && !wbWe && wbAdr == `OFS_STATUS |-> wbDatOut[31:7] == 25'h0)
    else $error("status read has upper bits set");
  a_wake_follow: assert property (wakeCpu == $past(lightSleep && (rxIrq || errIrq)))
    else $error("processor wake does not follow interrupt in light sleep");
  a_rx_irq_gate: assert property (rxIrq |-> $past(enShadow_reg[0] || enShadow_reg[1]))
    else $error("receive interrupt without enable");
  a_err_irq_gate: assert property (errIrq |-> $past(|enShadow_reg[5:2]))
    else $error("error interrupt without enable");
  a_irq_drop_bus: assert property ($fell(rxIrq) || $fell(errIrq) |-> wbAck || $past(wbAck))
    else $error("interrupt dropped without bus access");
  c_wake: cover property ($rose(wakeCpu));
  c_err: cover property ($rose(errIrq));
  c_rx: cover property ($rose(rxIrq));
endmodule // uart_rx_props
bind uart_receive_recovery uart_rx_props #(.DIV_W(DIV_W)) u_props (.sys_clk(sys_clk), .rst(rst),
  .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
  .wbDatOut(wbDatOut), .wbAck(wbAck), .rxd(rxd), .lightSleep(lightSleep), .deepSleep(deepSleep),
  .rxIrq(rxIrq), .errIrq(errIrq), .wakeCpu(wakeCpu));

// ### verification/tb.sv
// self-checking bench for the receive recovery block
`timescale 1ns/10ps
`include "uart_rx_map.vh"
module tb;
  reg sys_clk, rst, wbCyc, wbStb, wbWe, lightSleep, deepSleep;
  reg [7:0] wbAdr;
  reg [3:0] wbSel;
  reg [31:0] wbDatIn;
  reg [31:0] rdVal;
  wire [31:0] wbDatOut;
  wire wbAck, rxd, rxIrq, errIrq, wakeCpu;
  int fail_count = 0;
  int samples_checked = 0;
  int p;
  uart_receive_recovery #(.DIV_W(16)) u_dut (.sys_clk(sys_clk), .rst(rst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .rxd(rxd), .lightSleep(lightSleep),
    .deepSleep(deepSleep), .rxIrq(rxIrq), .errIrq(errIrq), .wakeCpu(wakeCpu));
  uart_tx_model u_tx (.sys_clk(sys_clk), .rxd(rxd));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ****************************************
  // compare, bus cycle and serial helpers
  // ****************************************
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'hF;
    wbDatIn <= d;
    for (n = 0; n < 20 && wbAck !== 1'b1; n++) @(posedge sys_clk);
    check("bus ack", wbAck, 32'h1);
    rdVal = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rdm(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(what, rdVal & m, e);
  endtask
  task tx(input logic [7:0] d, input logic [2:0] sp, input logic sn, input int per);
    u_tx.send(d, sp, sn, per);
    repeat (4) @(posedge sys_clk);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("unexpected watchdog: expected end seen hang");
    finish_test;
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    rst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatIn = 32'h0;
    lightSleep = 1'b0;
    deepSleep = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdm("ctrl reset", `OFS_CTRL, 32'hFF, 32'h00);
    rdm("irq enable reset", `OFS_IRQ_EN, 32'h3F, 32'h00);
    rdm("baud reset", `OFS_BAUD, 32'hFFFF, 32'h41);
    rdm("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, `OFS_BAUD, 32'h1);
    bus(1'b1, `OFS_IRQ_EN, 32'h3F);
    bus(1'b1, `OFS_CTRL, 32'h03);
    // let the receiver see five idle highs before the first start bit
    repeat (4) @(posedge sys_clk);
    // every stop sample pattern; pattern 000 goes with a break
    for (p = 0; p < 8; p++) begin
      tx((p == 0) ? 8'h00 : 8'h55, p[2:0], 1'b0, 16);
      check("rx irq", rxIrq, 32'h1);
      check("err irq", errIrq, p != 7);
      rdm("stop status", `OFS_STATUS, 32'h3D, {27'h0, p == 0 || p == 1 || p == 2 || p == 4,
        p != 0 && p != 7, 3'b001});
      rdm("stop data", `OFS_DATA, 32'h1FF, (p == 0) ? 32'h0 : 32'h55);
      bus(1'b1, `OFS_STATUS, 32'h3F);
    end
    tx(8'h11, 3'b111, 1'b0, 16);
    tx(8'h22, 3'b111, 1'b0, 16);
    check("overrun irq", errIrq, 32'h1);
    rdm("overrun status", `OFS_STATUS, 32'h3D, 32'h05);
    rdm("overrun data", `OFS_DATA, 32'h1FF, 32'h11);
    bus(1'b1, `OFS_STATUS, 32'h3F);
    tx(8'h55, 3'b111, 1'b1, 16);
    rdm("start noise", `OFS_STATUS, 32'h3D, 32'h09);
    bus(1'b1, `OFS_STATUS, 32'h3F);
    // slow sender drifts two clocks a bit
    tx(8'h55, 3'b111, 1'b0, 18);
    rdm("slow status", `OFS_STATUS, 32'h3D, 32'h01);
    rdm("slow data", `OFS_DATA, 32'h1FF, 32'h55);
    bus(1'b1, `OFS_STATUS, 32'h3F);
    bus(1'b1, `OFS_CTRL, 32'h23);
    tx(8'h01, 3'b111, 1'b0, 16);
    rdm("parity status", `OFS_STATUS, 32'h3D, 32'h21);
    bus(1'b1, `OFS_IRQ_EN, 32'h00);
    check("masked err irq", errIrq, 32'h0);
    check("masked rx irq", rxIrq, 32'h0);
    bus(1'b1, `OFS_IRQ_EN, 32'h3F);
    check("parity irq", errIrq, 32'h1);
    bus(1'b1, `OFS_STATUS, 32'h3F);
    bus(1'b1, `OFS_CTRL, 32'h8B);
    tx(8'h12, 3'b111, 1'b0, 16);
    check("standby irq", rxIrq, 32'h0);
    rdm("standby status", `OFS_STATUS, 32'h3D, 32'h00);
    tx(8'h92, 3'b111, 1'b0, 16);
    check("mark irq", rxIrq, 32'h1);
    rdm("mark ctrl", `OFS_CTRL, 32'hFF, 32'h0B);
    rdm("mark data", `OFS_DATA, 32'h1FF, 32'h92);
    bus(1'b1, `OFS_CTRL, 32'h8B);
    bus(1'b1, `OFS_STATUS, 32'h3F);
    bus(1'b1, `OFS_CTRL, 32'h83);
    repeat (200) @(posedge sys_clk);
    rdm("idle wake ctrl", `OFS_CTRL, 32'hFF, 32'h03);
    rdm("idle wake status", `OFS_STATUS, 32'h3F, 32'h00);
    tx(8'h55, 3'b111, 1'b0, 16);
    repeat (200) @(posedge sys_clk);
    rdm("idle status", `OFS_STATUS, 32'h3F, 32'h03);
    lightSleep <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("wake", wakeCpu, 32'h1);
    lightSleep <= 1'b0;
    bus(1'b1, `OFS_STATUS, 32'h3F);
    deepSleep <= 1'b1;
    tx(8'h33, 3'b111, 1'b0, 16);
    deepSleep <= 1'b0;
    rdm("frozen status", `OFS_STATUS, 32'h3D, 32'h00);
    rdm("kept ctrl", `OFS_CTRL, 32'hFF, 32'h03);
    // odd parity and idle counting only after the stop bit
    bus(1'b1, `OFS_CTRL, 32'h73);
    tx(8'h01, 3'b111, 1'b0, 16);
    repeat (200) @(posedge sys_clk);
    rdm("odd parity idle", `OFS_STATUS, 32'h3F, 32'h03);
    finish_test;
  end
endmodule // tb
